// *** include/cfg_ctrl_pkg.sv ***
package cfg_ctrl_pkg;

    // =========================================================
    // Scheme select encodings
    // =========================================================
    localparam int SCHEME_W = 4;
    localparam logic [SCHEME_W-1:0] SCHEME_PASSIVE_SERIAL  = 4'h0;
    localparam logic [SCHEME_W-1:0] SCHEME_ACTIVE_SERIAL   = 4'h2;
    localparam logic [SCHEME_W-1:0] SCHEME_ACTIVE_PARALLEL = 4'h5;
    localparam logic [SCHEME_W-1:0] SCHEME_FAST_PARALLEL   = 4'hC;

    // =========================================================
    // Timing
    // =========================================================
    localparam int CLK_PERIOD_NS = 40;
    localparam int POR_TIME_NS   = 1000;
    localparam int POR_CYCLES    = (POR_TIME_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int INIT_CYCLES   = 16;
    localparam int CNT_W         = 16;

    // =========================================================
    // Types
    // =========================================================
    typedef enum logic [1:0] {
        MODE_PASSIVE,
        MODE_ACTIVE_SERIAL,
        MODE_ACTIVE_PARALLEL
    } scheme_mode_t;

    typedef enum logic [2:0] {
        ST_POR,
        ST_RESET,
        ST_CONFIG,
        ST_WAIT_DONE,
        ST_INIT,
        ST_USER,
        ST_ERROR
    } cfg_state_t;

    // One open-drain pin seen from inside: level in, pull-low drive
    typedef struct packed {
        logic level;
        logic drive_low;
    } od_pin_t;

    // Configuration-data core feedback
    typedef struct packed {
        logic data_complete;
        logic data_error;
    } load_status_t;

endpackage : cfg_ctrl_pkg

// *** logic/config_control_handshake.sv ***
`timescale 1ns/1ps
module config_control_handshake
    import cfg_ctrl_pkg::*;
#(
    parameter int POR_COUNT  = POR_CYCLES,
    parameter int INIT_COUNT = INIT_CYCLES
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic [SCHEME_W-1:0] scheme_select_i,
    input  wire logic                config_request_n_i,
    input  wire logic                chip_enable_n_i,
    input  wire load_status_t        load_status_i,
    input  wire logic                mem_select_req_i,
    input  wire logic                chain_dedicated_i,
    input  wire logic                chain_user_oe_i,
    input  wire logic                chain_user_out_i,
    input  wire logic                status_pad_i,
    output logic                     status_pad_o,
    output logic                     status_pad_oe_o,
    input  wire logic                cfg_complete_pad_i,
    output logic                     cfg_complete_pad_o,
    output logic                     cfg_complete_pad_oe_o,
    input  wire logic                chain_enable_out_n_pad_i,
    output logic                     chain_enable_out_n_pad_o,
    output logic                     chain_enable_out_n_pad_oe_o,
    output logic                     mem_enable_n_o,
    output logic                     load_enable_o,
    output logic                     load_clear_o,
    output logic                     user_io_enable_o,
    output logic                     user_mode_o,
    output scheme_mode_t             scheme_mode_o,
    output logic                     error_o
);

    // =========================================================
    // State and registers
    // =========================================================
    cfg_state_t           state_reg,  state_next;
    logic [CNT_W-1:0]     cnt_reg,    cnt_next;
    logic                 req_n_reg;
    scheme_mode_t         mode_reg,   mode_next;
    logic                 mode_load;
    logic                 mem_en_n_reg, mem_en_n_next;
    logic                 chain_low_reg, chain_low_next;
    logic                 status_low_reg, status_low_next;
    logic                 done_low_reg, done_low_next;

    // Pad levels as the wired-AND resolves them
    logic status_level;
    logic done_level;

    // Counter end points: a count of N runs N cycles
    localparam logic [CNT_W-1:0] POR_LAST  = CNT_W'(POR_COUNT - 1);
    localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_COUNT - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;

    // =========================================================
    // Open-drain pads
    // =========================================================
    // Status: power-on hold, errors and reset
    od_pin_driver u_status (
        .pull_low_i (status_low_reg),
        .pad_i      (status_pad_i),
        .pad_o      (status_pad_o),
        .pad_oe_o   (status_pad_oe_o),
        .level_o    (status_level)
    );

    // Done: let go only after a clean load
    od_pin_driver u_done (
        .pull_low_i (done_low_reg),
        .pad_i      (cfg_complete_pad_i),
        .pad_o      (cfg_complete_pad_o),
        .pad_oe_o   (cfg_complete_pad_oe_o),
        .level_o    (done_level)
    );

    // User-mode chain pin: driven by user logic if not dedicated
    wire chain_as_user = ~chain_dedicated_i
                         & (state_reg == ST_USER);
    wire chain_pull    = chain_as_user
                         ? (chain_user_oe_i & ~chain_user_out_i)
                         : chain_low_reg;

    od_pin_driver u_chain (
        .pull_low_i (chain_pull),
        .pad_i      (chain_enable_out_n_pad_i),
        .pad_o      (chain_enable_out_n_pad_o),
        .pad_oe_o   (chain_enable_out_n_pad_oe_o),
        .level_o    ()
    );

    // =========================================================
    // Request edge detect
    // =========================================================
    // Only the fall resets; a held-low request cannot retrigger
    wire req_fall  = req_n_reg & ~config_request_n_i;
    wire req_low   = ~config_request_n_i;

    // =========================================================
    // Decode
    // =========================================================
    wire loading   = (state_reg == ST_CONFIG)
                     | (state_reg == ST_WAIT_DONE);
    // Status pin only listened to while loading or initializing
    wire ext_fault = ~status_level & ~status_low_reg
                     & (loading | (state_reg == ST_INIT));
    wire load_ok   = load_status_i.data_complete
                     & ~load_status_i.data_error;
    // One counter serves both the power-on and init timers
    wire por_end   = (cnt_reg == POR_LAST);
    wire init_end  = (cnt_reg == INIT_LAST);

    // Straps sampled only in reset states; later changes ignored
    always_comb begin
        // Unknown strap codes fall back to passive loading
        unique case (scheme_select_i)
            SCHEME_ACTIVE_SERIAL:   mode_next = MODE_ACTIVE_SERIAL;
            SCHEME_ACTIVE_PARALLEL: mode_next = MODE_ACTIVE_PARALLEL;
            default:                mode_next = MODE_PASSIVE;
        endcase
    end

    assign mode_load = (state_reg == ST_POR)
                       | (state_reg == ST_RESET);

    // =========================================================
    // Next state
    // =========================================================
    always_comb begin
        state_next      = state_reg;
        cnt_next        = cnt_reg;
        status_low_next = 1'b0;
        done_low_next   = 1'b1;
        chain_low_next  = chain_low_reg;
        unique case (state_reg)
            ST_POR: begin
                status_low_next = 1'b1;
                cnt_next        = cnt_reg + CNT_ONE;
                if (por_end) begin
                    state_next      = ST_RESET;
                    status_low_next = 1'b0;
                    cnt_next        = CNT_ZERO;
                end
            end
            ST_RESET: begin
                chain_low_next  = 1'b0;
                status_low_next = req_low;
                // Level test: a request already high after power-on loads
                if (!req_low) begin
                    state_next = ST_CONFIG;
                end
            end
            ST_CONFIG: begin
                // A data error is fatal even with chip enable high
                if (load_status_i.data_error || ext_fault) begin
                    state_next      = ST_ERROR;
                    status_low_next = 1'b1;
                end else if (load_ok && !chip_enable_n_i) begin
                    state_next    = ST_WAIT_DONE;
                    done_low_next = 1'b0;
                end
            end
            ST_WAIT_DONE: begin
                done_low_next = 1'b0;
                if (ext_fault) begin
                    state_next      = ST_ERROR;
                    status_low_next = 1'b1;
                // Waits until every device on the wired line lets go
                end else if (done_level) begin
                    state_next = ST_INIT;
                    cnt_next   = CNT_ZERO;
                end
            end
            ST_INIT: begin
                // Faults still count until user mode is reached
                done_low_next = 1'b0;
                cnt_next      = cnt_reg + CNT_ONE;
                if (ext_fault) begin
                    state_next      = ST_ERROR;
                    status_low_next = 1'b1;
                end else if (init_end) begin
                    state_next     = ST_USER;
                    chain_low_next = 1'b1;
                end
            end
            ST_USER: begin
                // Done and status pins are not looked at here
                done_low_next = 1'b0;
            end
            ST_ERROR: begin
                // Held until the host pulls the request low again
                status_low_next = 1'b1;
            end
            default: begin
                state_next = ST_RESET;
            end
        endcase
        // A request fall always wins, from any state but power-on
        if (req_fall && state_reg != ST_POR) begin
            state_next      = ST_RESET;
            status_low_next = 1'b1;
            done_low_next   = 1'b1;
            chain_low_next  = 1'b0;
        end
    end

    // Memory enable: one pin serves the active serial and active parallel schemes
    always_comb begin
        mem_en_n_next = 1'b1;
        if (loading && mode_reg != MODE_PASSIVE) begin
            mem_en_n_next = ~mem_select_req_i;
        end
    end

    // =========================================================
    // Registers
    // =========================================================
    // Control state and its shared timer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_POR;
            cnt_reg   <= CNT_ZERO;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // Idles high so leaving reset never reads as a request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_n_reg <= 1'b1;
        end else begin
            req_n_reg <= config_request_n_i;
        end
    end

    // Scheme latched only while unconfigured; later strap noise is moot
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg <= MODE_PASSIVE;
        end else if (mode_load) begin
            mode_reg <= mode_next;
        end
    end

    // Open-drain pulls: status and done start pulled low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_low_reg <= 1'b1;
            done_low_reg   <= 1'b1;
            chain_low_reg  <= 1'b0;
        end else begin
            status_low_reg <= status_low_next;
            done_low_reg   <= done_low_next;
            chain_low_reg  <= chain_low_next;
        end
    end

    // Registered so the memory select never glitches
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_en_n_reg <= 1'b1;
        end else begin
            mem_en_n_reg <= mem_en_n_next;
        end
    end

    // =========================================================
    // Outputs
    // =========================================================
    assign mem_enable_n_o   = mem_en_n_reg;
    assign load_enable_o    = (state_reg == ST_CONFIG)
                              & ~chip_enable_n_i;
    // Loader drops any partial image while in reset
    assign load_clear_o     = (state_reg == ST_RESET);
    assign user_mode_o      = (state_reg == ST_USER);
    // User I/O tri-stated everywhere outside user mode
    assign user_io_enable_o = (state_reg == ST_USER);
    assign scheme_mode_o    = mode_reg;
    assign error_o          = (state_reg == ST_ERROR);

endmodule : config_control_handshake

// *** logic/od_pin_driver.sv ***
`timescale 1ns/1ps
// Open-drain pad: output stays low, enable asserted only to pull low
module od_pin_driver
    import cfg_ctrl_pkg::*;
(
    input  wire logic pull_low_i,
    input  wire logic pad_i,
    output logic      pad_o,
    output logic      pad_oe_o,
    output logic      level_o
);
    assign pad_o    = 1'b0;
    assign pad_oe_o = pull_low_i;
    // Wired-AND: own pull wins even if pad sample lags
    assign level_o  = pad_i & ~pull_low_i;
endmodule : od_pin_driver

// *** tb/cfg_host.sv ***
`timescale 1ns/1ps
// ====
// Board side: pull-ups plus host drivers
module cfg_host (
    input  wire logic status_oe_i,
    input  wire logic done_oe_i,
    input  wire logic chain_oe_i,
    input  wire logic pull_status_i,
    input  wire logic pull_done_i,
    output logic      status_o,
    output logic      done_o,
    output logic      chain_o,
    output logic      next_ce_n_o
);
    // Any low driver wins over the pull-up
    assign status_o    = ~(status_oe_i | pull_status_i);
    assign done_o      = ~(done_oe_i | pull_done_i);
    assign chain_o     = ~chain_oe_i;
    assign next_ce_n_o = chain_o;
endmodule : cfg_host

// *** tb/config_control_handshake_chk.sv ***
`timescale 1ns/1ps
module config_control_handshake_chk
    import cfg_ctrl_pkg::*;
(
    input wire logic         clk_i,
    input wire logic         rst_i,
    input wire logic         config_request_n_i,
    input wire logic         chip_enable_n_i,
    input wire load_status_t load_status_i,
    input wire logic         mem_select_req_i,
    input wire logic         chain_dedicated_i,
    input wire logic         status_pad_i,
    input wire logic         status_pad_oe_o,
    input wire logic         cfg_complete_pad_i,
    input wire logic         cfg_complete_pad_oe_o,
    input wire logic         chain_enable_out_n_pad_oe_o,
    input wire logic         mem_enable_n_o,
    input wire logic         load_enable_o,
    input wire logic         user_mode_o,
    input wire logic         error_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence load_ok;
        load_enable_o && config_request_n_i && status_pad_i
            && load_status_i.data_complete && !load_status_i.data_error;
    endsequence
    sequence user_quiet;
        user_mode_o && config_request_n_i;
    endsequence
    a_req_fall_reset: assert property ($fell(config_request_n_i)
        && user_mode_o |=> !user_mode_o && status_pad_oe_o)
        else $error("request fall kept user mode");
    a_load_needs_ce: assert property (load_enable_o |-> !chip_enable_n_i)
        else $error("load enabled without chip enable");
    a_status_ignored: assert property (user_quiet ##0 !status_pad_i
        |=> user_mode_o) else $error("status low left user mode");
    a_done_ignored: assert property (user_quiet ##0 !cfg_complete_pad_i
        |=> user_mode_o) else $error("done low left user mode");
    a_error_status: assert property (error_o |-> status_pad_oe_o)
        else $error("error without status pulled low");
    a_ext_status_err: assert property (load_enable_o && config_request_n_i
        && !status_pad_i && !status_pad_oe_o |=> error_o)
        else $error("external status low not taken as error");
    a_done_held: assert property (load_enable_o |-> cfg_complete_pad_oe_o)
        else $error("done released during load");
    a_done_release: assert property (load_ok |=> !cfg_complete_pad_oe_o)
        else $error("done not released after load");
    a_chain_low: assert property ($rose(user_mode_o) && chain_dedicated_i
        |-> ##[0:1] chain_enable_out_n_pad_oe_o)
        else $error("chain enable not driven low");
    a_mem_idle: assert property (!mem_select_req_i ##1 !mem_select_req_i
        |-> mem_enable_n_o) else $error("memory enabled without request");
endmodule : config_control_handshake_chk

bind config_control_handshake config_control_handshake_chk chk_u (.*);

// *** tb/config_control_handshake_tb.sv ***
`timescale 1ns/1ps
module config_control_handshake_tb;
    import cfg_ctrl_pkg::*;
    logic [SCHEME_W-1:0] scheme_select_i;
    load_status_t        load_status_i;
    scheme_mode_t        scheme_mode_o;
    logic clk_i, rst_i, config_request_n_i, chip_enable_n_i, mem_select_req_i;
    logic chain_dedicated_i, chain_user_oe_i, chain_user_out_i;
    logic status_pad_i, cfg_complete_pad_i, chain_enable_out_n_pad_i;
    logic status_pad_oe_o, cfg_complete_pad_oe_o, chain_enable_out_n_pad_oe_o;
    logic mem_enable_n_o, load_enable_o, load_clear_o, user_io_enable_o;
    logic user_mode_o, error_o, pull_status, pull_done, next_ce_n;
    logic status_pad_o, cfg_complete_pad_o, chain_enable_out_n_pad_o;
    int   error_cnt, tests_run;

    config_control_handshake #(.POR_COUNT(2), .INIT_COUNT(2)) dut_u (.*);
    cfg_host host_u (
        .status_oe_i(status_pad_oe_o), .done_oe_i(cfg_complete_pad_oe_o),
        .chain_oe_i(chain_enable_out_n_pad_oe_o), .pull_status_i(pull_status),
        .pull_done_i(pull_done), .status_o(status_pad_i),
        .done_o(cfg_complete_pad_i), .chain_o(chain_enable_out_n_pad_i),
        .next_ce_n_o(next_ce_n));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // ====
    // Shared helpers
    task automatic chk(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    // Bounded wait for load enable or user mode
    task automatic wait_for(input logic want_user);
        for (int i = 0; i < 60; i++) begin
            @(posedge clk_i);
            #1;
            if ((want_user ? user_mode_o : load_enable_o) === 1'b1) return;
        end
        chk("wait_done", 1'b1, 1'b0);
        end_of_test();
    endtask : wait_for
    task automatic restart();
        @(posedge clk_i) config_request_n_i <= 1'b0;
        @(posedge clk_i) config_request_n_i <= 1'b1;
        wait_for(1'b0);
    endtask : restart
    task automatic load_all();
        @(posedge clk_i) load_status_i <= 2'h2;
        @(posedge clk_i) load_status_i <= 2'h0;
        #1 chk("done_oe", 1'b0, cfg_complete_pad_oe_o);
        repeat (2) @(posedge clk_i);
        #1 chk("early_user", 1'b0, user_mode_o);
        @(posedge clk_i);
        #1 chk("user_mode", 1'b1, user_mode_o);
        chk("chain_oe", 1'b1, chain_enable_out_n_pad_oe_o);
        chk("next_ce", 1'b0, next_ce_n);
    endtask : load_all
    // ====
    // Scenarios
    task automatic t_power_up();
        #1 chk("por_status", 1'b1, status_pad_oe_o);
        chk("por_done", 1'b1, cfg_complete_pad_oe_o);
        chk("od_out", 1'b0, status_pad_o | cfg_complete_pad_o);
        chk("od_chain", 1'b0, chain_enable_out_n_pad_o);
        wait_for(1'b0);
        chk("status_free", 1'b0, status_pad_oe_o);
    endtask : t_power_up
    task automatic t_schemes();
        logic [SCHEME_W-1:0] s [4] = '{SCHEME_ACTIVE_SERIAL,
            SCHEME_ACTIVE_PARALLEL, SCHEME_PASSIVE_SERIAL, SCHEME_FAST_PARALLEL};
        scheme_mode_t m [4] = '{MODE_ACTIVE_SERIAL, MODE_ACTIVE_PARALLEL,
            MODE_PASSIVE, MODE_PASSIVE};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i) scheme_select_i <= s[i];
            restart();
            @(posedge clk_i) mem_select_req_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            #1 chk("mem_en_n", m[i] == MODE_PASSIVE, mem_enable_n_o);
            chk("scheme", 1'b1, scheme_mode_o === m[i]);
            @(posedge clk_i) mem_select_req_i <= 1'b0;
            load_all();
        end
    endtask : t_schemes
    task automatic t_user_pins();
        @(posedge clk_i) pull_status <= 1'b1;
        pull_done <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1 chk("keep_user", 1'b1, user_mode_o);
        chk("no_error", 1'b0, error_o);
        @(posedge clk_i) pull_status <= 1'b0;
        pull_done <= 1'b0;
        chain_dedicated_i <= 1'b0;
        #1 chk("chain_user_off", 1'b0, chain_enable_out_n_pad_oe_o);
        @(posedge clk_i) chain_user_oe_i <= 1'b1;
        #1 chk("chain_user_lo", 1'b1, chain_enable_out_n_pad_oe_o);
        @(posedge clk_i) chain_user_out_i <= 1'b1;
        #1 chk("chain_user_hi", 1'b0, chain_enable_out_n_pad_oe_o);
        @(posedge clk_i) chain_dedicated_i <= 1'b1;
    endtask : t_user_pins
    task automatic t_reconfig();
        @(posedge clk_i) config_request_n_i <= 1'b0;
        @(posedge clk_i);
        #1 chk("user_drop", 1'b0, user_mode_o);
        chk("io_off", 1'b0, user_io_enable_o);
        chk("discard", 1'b1, load_clear_o);
        chk("reset_status", 1'b1, status_pad_oe_o);
        @(posedge clk_i) config_request_n_i <= 1'b1;
        wait_for(1'b0);
        load_all();
    endtask : t_reconfig
    task automatic t_faults();
        restart();
        @(posedge clk_i) chip_enable_n_i <= 1'b1;
        load_status_i <= 2'h2;
        repeat (2) @(posedge clk_i);
        #1 chk("ce_block", 1'b1, cfg_complete_pad_oe_o);
        chk("ce_load", 1'b0, load_enable_o);
        @(posedge clk_i) chip_enable_n_i <= 1'b0;
        load_status_i <= 2'h1;
        repeat (2) @(posedge clk_i);
        #1 chk("data_err", 1'b1, error_o);
        chk("err_status", 1'b1, status_pad_oe_o);
        @(posedge clk_i) load_status_i <= 2'h0;
        restart();
        @(posedge clk_i) pull_status <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1 chk("ext_err", 1'b1, error_o);
        @(posedge clk_i) pull_status <= 1'b0;
        restart();
        load_all();
    endtask : t_faults

    initial begin
        {rst_i, config_request_n_i, chain_dedicated_i} = 3'h7;
        {chip_enable_n_i, mem_select_req_i, pull_status, pull_done} = 4'h0;
        {chain_user_oe_i, chain_user_out_i} = 2'h0;
        load_status_i = 2'h0;
        scheme_select_i = SCHEME_PASSIVE_SERIAL;
        error_cnt = 0;
        tests_run = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_power_up();
        t_schemes();
        t_user_pins();
        t_reconfig();
        t_faults();
        end_of_test();
    end
endmodule : config_control_handshake_tb
